//--- inc/roi_window_defines.vh
// Purpose: Constants for the region-of-interest window configuration block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes: Printed offsets are word indices; byte address is four times the index
`ifndef ROI_WINDOW_DEFINES_VH
`define ROI_WINDOW_DEFINES_VH

// Printed register indices (windows 6 to 8)
`define IDX_V_SIZE_ROW6 10'h03e
`define IDX_H_POS_COL7 10'h040
`define IDX_V_POS_ROW7 10'h042
`define IDX_H_SIZE_COL7 10'h044
`define IDX_V_SIZE_ROW7 10'h046
`define IDX_H_POS_COL8 10'h048
`define IDX_V_POS_ROW8 10'h04a
`define IDX_H_SIZE_COL8 10'h04c
`define IDX_V_SIZE_ROW8 10'h04e

// Coined registers, word indices
`define IDX_CONTROL 10'h060
`define IDX_LINE_CLOCKS 10'h061
`define IDX_LINES_PER_FRAME 10'h062
`define IDX_FRAME_CLOCKS 10'h063
`define IDX_STATUS 10'h064
`define IDX_H_WIDTH_SUM 10'h065

// Field widths and reset values
`define H_WIDTH 13
`define V_WIDTH 12
`define H_RESET 13'h0000
`define V_RESET 12'h000

// Constraint figures
`define H_LIMIT 16'h09a0
`define V_LIMIT 16'h0808
`define H_MIN_WIDE 16'h0102
`define H_MIN_NARROW 16'h0204
`define V_MIN_SUM 16'h0004
`define V_BLANK_LINES 16'h0026

// Line clock count loaded out of reset
`define LINE_CLOCKS_RESET 16'h015e

// Control fields
`define CTRL_REGION_EN 0
`define CTRL_BITS8 1
`define CTRL_APPLY 2
`define CTRL_DATA_RATE 3

`endif

//--- src/roi_window_crop_config.v
// Purpose: Window registers, constraint checks and frame timing for region readout
// Assumes: Host writes windows 1 to 5 and window 6 position and width on the window ports; clk is the input clock
// Notes: Window set is shadowed and takes effect on an apply write
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "roi_window_defines.vh"

// What this block does
// - Row 8 position applies to whole row
// - Column 8 width from its own field
// - Horizontal position is 13 bits wide
// - Vertical values 12 bits, reset zero
// - Frame lines equal heights plus 38
// - Frame period is lines times line period
// - Line period counted in input clocks
module roi_window_crop_config #(
    parameter NWIN = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Windows 1 to 5 and window 6 position and width from the rest of the register map, packed window 1 lowest
    input wire [5*`H_WIDTH-1:0] lowHPos,
    input wire [5*`H_WIDTH-1:0] lowHWidth,
    input wire [5*`V_WIDTH-1:0] lowVPos,
    input wire [5*`V_WIDTH-1:0] lowVHeight,
    input wire [`V_WIDTH-1:0] vPosRow6,
    input wire [`H_WIDTH-1:0] hPosCol6,
    input wire [`H_WIDTH-1:0] hWidthCol6,
    // Active window set and derived timing
    output reg [NWIN*`H_WIDTH-1:0] activeHPos,
    output reg [NWIN*`H_WIDTH-1:0] activeHWidth,
    output reg [NWIN*`V_WIDTH-1:0] activeVPos,
    output reg [NWIN*`V_WIDTH-1:0] activeVHeight,
    output reg [15:0] linesPerFrame,
    output reg [31:0] frameClocks,
    output reg configValid,
    output reg regionEnable
);

    // Software-visible window registers for indices 6 to 8
    reg [`V_WIDTH-1:0] vSizeRow6;
    reg [`H_WIDTH-1:0] hPosCol7;
    reg [`V_WIDTH-1:0] vPosRow7;
    reg [`H_WIDTH-1:0] hSizeCol7;
    reg [`V_WIDTH-1:0] vSizeRow7;
    reg [`H_WIDTH-1:0] hPosCol8;
    reg [`V_WIDTH-1:0] vPosRow8;
    reg [`H_WIDTH-1:0] hSizeCol8;
    reg [`V_WIDTH-1:0] vSizeRow8;
    reg ctlRegion;
    reg ctlBits8;
    reg dataRate;
    reg [15:0] lineClocks;
    reg applyPending;

    wire [9:0] wordIdx;
    wire access;
    wire wrEn;
    assign wordIdx = paddr[11:2];
    assign access = psel & penable & ~pready;
    assign wrEn = access & pwrite;

    // Gather current window set, window 1 lowest
    wire [NWIN*`H_WIDTH-1:0] curHPos;
    wire [NWIN*`H_WIDTH-1:0] curHWidth;
    wire [NWIN*`V_WIDTH-1:0] curVPos;
    wire [NWIN*`V_WIDTH-1:0] curVHeight;
    assign curHPos = {hPosCol8, hPosCol7, hPosCol6, lowHPos};
    assign curHWidth = {hSizeCol8, hSizeCol7, hWidthCol6, lowHWidth};
    assign curVPos = {vPosRow8, vPosRow7, vPosRow6, lowVPos};
    assign curVHeight = {vSizeRow8, vSizeRow7, vSizeRow6, lowVHeight};

    // Per-window checks and running sums
    wire [NWIN-1:0] hOk;
    wire [NWIN-1:0] vOk;
    wire [NWIN-1:0] alignOk;
    wire [15:0] hSum [0:NWIN];
    wire [15:0] vSum [0:NWIN];
    assign hSum[0] = 16'h0000;
    assign vSum[0] = 16'h0000;
    genvar i;
    generate
        for (i = 0; i < NWIN; i = i + 1) begin : win
            wire [`H_WIDTH-1:0] hPosW;
            wire [`H_WIDTH-1:0] hWidW;
            wire [`V_WIDTH-1:0] vPosW;
            wire [`V_WIDTH-1:0] vHgtW;
            wire [15:0] hEnd;
            wire [15:0] vEnd;
            wire [15:0] hNext;
            wire [15:0] vNext;
            assign hPosW = curHPos[i*`H_WIDTH +: `H_WIDTH];
            assign hWidW = curHWidth[i*`H_WIDTH +: `H_WIDTH];
            assign vPosW = curVPos[i*`V_WIDTH +: `V_WIDTH];
            assign vHgtW = curVHeight[i*`V_WIDTH +: `V_WIDTH];
            // Widened first so an end sum cannot wrap past the limit
            assign hEnd = {3'h0, hPosW} + {3'h0, hWidW};
            assign vEnd = {4'h0, vPosW} + {4'h0, vHgtW};
            if (i == NWIN - 1) begin : last
                assign hNext = `H_LIMIT;
                assign vNext = `V_LIMIT;
            end else begin : mid
                assign hNext = {3'h0, curHPos[(i+1)*`H_WIDTH +: `H_WIDTH]};
                assign vNext = {4'h0, curVPos[(i+1)*`V_WIDTH +: `V_WIDTH]};
            end
            assign hOk[i] = hEnd < hNext;
            assign vOk[i] = vEnd < vNext;
            // Granularity is not forced on write; a misaligned set clears the valid flag
            assign alignOk[i] = (hPosW[1:0] == 2'h0) && (hWidW[1:0] == 2'h0)
                && (vPosW[1:0] == 2'h0) && (vHgtW[1:0] == 2'h0);
            assign hSum[i+1] = hSum[i] + {3'h0, hWidW};
            assign vSum[i+1] = vSum[i] + {4'h0, vHgtW};
        end
    endgenerate

    wire hMinOk;
    wire vMinOk;
    wire alignAll;
    wire orderOk;
    wire sizeOk;
    wire allOk;
    wire [15:0] next_linesPerFrame;
    wire [31:0] next_frameClocks;
    assign hMinOk = hSum[NWIN] >= (ctlBits8 ? `H_MIN_NARROW : `H_MIN_WIDE);
    assign vMinOk = vSum[NWIN] >= `V_MIN_SUM;
    assign alignAll = &alignOk;
    assign orderOk = (&hOk) & (&vOk);
    assign sizeOk = hMinOk & vMinOk;
    // A failing set still applies; the cleared valid flag keeps readout off
    assign allOk = alignAll & orderOk & sizeOk;
    assign next_linesPerFrame = vSum[NWIN] + `V_BLANK_LINES;
    assign next_frameClocks = {16'h0000, linesPerFrame} * {16'h0000, lineClocks};

    // Read data for the addressed word; unmapped words answer with an error
    reg [31:0] next_prdata;
    reg next_pslverr;
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (wordIdx)
            `IDX_V_SIZE_ROW6: begin
                next_prdata = {20'h00000, vSizeRow6};
            end
            `IDX_H_POS_COL7: begin
                next_prdata = {19'h00000, hPosCol7};
            end
            `IDX_V_POS_ROW7: begin
                next_prdata = {20'h00000, vPosRow7};
            end
            `IDX_H_SIZE_COL7: begin
                next_prdata = {19'h00000, hSizeCol7};
            end
            `IDX_V_SIZE_ROW7: begin
                next_prdata = {20'h00000, vSizeRow7};
            end
            `IDX_H_POS_COL8: begin
                next_prdata = {19'h00000, hPosCol8};
            end
            `IDX_V_POS_ROW8: begin
                next_prdata = {20'h00000, vPosRow8};
            end
            `IDX_H_SIZE_COL8: begin
                next_prdata = {19'h00000, hSizeCol8};
            end
            `IDX_V_SIZE_ROW8: begin
                next_prdata = {20'h00000, vSizeRow8};
            end
            `IDX_CONTROL: begin
                // Apply is a strobe and reads back as zero
                next_prdata = {28'h0000000, dataRate, 1'b0, ctlBits8, ctlRegion};
            end
            `IDX_LINE_CLOCKS: begin
                next_prdata = {16'h0000, lineClocks};
            end
            `IDX_LINES_PER_FRAME: begin
                next_prdata = {16'h0000, linesPerFrame};
            end
            `IDX_FRAME_CLOCKS: begin
                next_prdata = frameClocks;
            end
            `IDX_STATUS: begin
                next_prdata = {27'h0000000, alignAll, vMinOk, hMinOk, &vOk, &hOk};
            end
            `IDX_H_WIDTH_SUM: begin
                next_prdata = {16'h0000, hSum[NWIN]};
            end
            default: begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    // One wait state: the answer is registered from the taken edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access & next_pslverr;
            if (access) begin
                prdata <= next_prdata;
            end
        end
    end

    // Horizontal window registers; write bits above the field are dropped
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hPosCol7 <= `H_RESET;
            hSizeCol7 <= `H_RESET;
            hPosCol8 <= `H_RESET;
            hSizeCol8 <= `H_RESET;
        end else if (wrEn) begin
            case (wordIdx)
                `IDX_H_POS_COL7: begin
                    hPosCol7 <= pwdata[`H_WIDTH-1:0];
                end
                `IDX_H_SIZE_COL7: begin
                    hSizeCol7 <= pwdata[`H_WIDTH-1:0];
                end
                `IDX_H_POS_COL8: begin
                    hPosCol8 <= pwdata[`H_WIDTH-1:0];
                end
                `IDX_H_SIZE_COL8: begin
                    hSizeCol8 <= pwdata[`H_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Vertical window registers, all zero out of reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vSizeRow6 <= `V_RESET;
            vPosRow7 <= `V_RESET;
            vSizeRow7 <= `V_RESET;
            vPosRow8 <= `V_RESET;
            vSizeRow8 <= `V_RESET;
        end else if (wrEn) begin
            case (wordIdx)
                `IDX_V_SIZE_ROW6: begin
                    vSizeRow6 <= pwdata[`V_WIDTH-1:0];
                end
                `IDX_V_POS_ROW7: begin
                    vPosRow7 <= pwdata[`V_WIDTH-1:0];
                end
                `IDX_V_SIZE_ROW7: begin
                    vSizeRow7 <= pwdata[`V_WIDTH-1:0];
                end
                `IDX_V_POS_ROW8: begin
                    vPosRow8 <= pwdata[`V_WIDTH-1:0];
                end
                `IDX_V_SIZE_ROW8: begin
                    vSizeRow8 <= pwdata[`V_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Control and line period; apply lives for one cycle only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctlRegion <= 1'b0;
            ctlBits8 <= 1'b0;
            dataRate <= 1'b0;
            lineClocks <= `LINE_CLOCKS_RESET;
            applyPending <= 1'b0;
        end else begin
            applyPending <= 1'b0;
            if (wrEn) begin
                case (wordIdx)
                    `IDX_CONTROL: begin
                        ctlRegion <= pwdata[`CTRL_REGION_EN];
                        ctlBits8 <= pwdata[`CTRL_BITS8];
                        dataRate <= pwdata[`CTRL_DATA_RATE];
                        applyPending <= pwdata[`CTRL_APPLY];
                    end
                    `IDX_LINE_CLOCKS: begin
                        // Host loads the count matching data rate and channel count
                        lineClocks <= pwdata[15:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Shadow set: readout sees a complete window set only after apply
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            activeHPos <= {NWIN*`H_WIDTH{1'b0}};
            activeHWidth <= {NWIN*`H_WIDTH{1'b0}};
            activeVPos <= {NWIN*`V_WIDTH{1'b0}};
            activeVHeight <= {NWIN*`V_WIDTH{1'b0}};
            linesPerFrame <= `V_BLANK_LINES;
            configValid <= 1'b0;
        end else if (applyPending) begin
            // One position per column and per row covers the whole grid line
            activeHPos <= curHPos;
            activeHWidth <= curHWidth;
            activeVPos <= curVPos;
            activeVHeight <= curVHeight;
            linesPerFrame <= next_linesPerFrame;
            configValid <= allOk;
        end
    end

    // Frame timing and enable trail the applied set by one cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frameClocks <= 32'h00000000;
            regionEnable <= 1'b0;
        end else begin
            frameClocks <= next_frameClocks;
            regionEnable <= ctlRegion & configValid;
        end
    end

endmodule
`default_nettype wire

//--- sim/roi_window_crop_config_properties.sv
// Purpose: Handshake, apply and frame timing properties of the window block
// Assumes: Sees only the top module ports
// Notes: Apply latency allowed one to three cycles after the taken edge
`timescale 1ns/1ps
`default_nettype none
`include "roi_window_defines.vh"
module roi_window_crop_config_properties #(
    parameter NWIN = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Applied set and timing
    input wire logic [NWIN*`H_WIDTH-1:0] activeHPos,
    input wire logic [NWIN*`V_WIDTH-1:0] activeVHeight,
    input wire logic [15:0] linesPerFrame,
    input wire logic [31:0] frameClocks,
    input wire logic configValid,
    input wire logic regionEnable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire applyWr = psel && penable && pwrite && !pready && paddr[11:2] == `IDX_CONTROL && pwdata[`CTRL_APPLY];
    function automatic int vsum(input logic [NWIN*`V_WIDTH-1:0] v);
        int s = 0;
        for (int i = 0; i < NWIN; i++) s += v[i*`V_WIDTH+:`V_WIDTH];
        return s;
    endfunction
    property p_take_answer; psel && penable && !pready |=> pready; endproperty
    a_take_answer: assert property (p_take_answer) else $error("No answer after taken request");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("Error without ready");
    property p_lines; linesPerFrame == vsum(activeVHeight) + 38; endproperty
    a_lines: assert property (p_lines) else $error("Frame lines not heights plus blank");
    property p_frame; $past(linesPerFrame) != 0 |-> frameClocks % $past(linesPerFrame) == 0; endproperty
    a_frame: assert property (p_frame) else $error("Frame clocks not a multiple of lines");
    property p_enable; regionEnable |-> $past(configValid); endproperty
    a_enable: assert property (p_enable) else $error("Region enabled on invalid set");
    property p_active; $changed(activeVHeight) || $changed(activeHPos) |-> $past(applyWr) || $past(applyWr, 2) || $past(applyWr, 3); endproperty
    a_active: assert property (p_active) else $error("Window set changed without apply");
    property p_valid; $changed(configValid) |-> $past(applyWr) || $past(applyWr, 2) || $past(applyWr, 3); endproperty
    a_valid: assert property (p_valid) else $error("Check result changed without apply");
endmodule
bind roi_window_crop_config roi_window_crop_config_properties #(.NWIN(NWIN)) u_props (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .activeHPos, .activeVHeight, .linesPerFrame,
    .frameClocks, .configValid, .regionEnable);
`default_nettype wire

//--- sim/host_apb_master.sv
// Purpose: Camera host model on the register bus
// Assumes: One transfer at a time
// Notes: Waits on pready without a count; the bench watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
module host_apb_master (
    // Bus
    input wire logic clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the window crop configuration block
// Assumes: Host model owns the bus; windows 1 to 5 and window 6 position and width come from ports here
// Notes: Model arrays give the expected window values; reset reads expect constants
`timescale 1ns/1ps
`default_nettype none
`include "roi_window_defines.vh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, configValid, regionEnable, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, frameClocks, q;
    logic [64:0] lowHPos = '0, lowHWidth = '0;
    logic [59:0] lowVPos = '0, lowVHeight = '0;
    logic [11:0] vPosRow6 = '0;
    logic [12:0] hPosCol6 = '0, hWidthCol6 = '0;
    logic [103:0] activeHPos, activeHWidth;
    logic [95:0] activeVPos, activeVHeight;
    logic [15:0] linesPerFrame;
    logic [31:0] lfsr = 32'h8729;
    int fails = 0, checked = 0, lineClk, st;
    int m[4][8]; // Kinds: h position, v position, h width, v height
    always #20 clk = ~clk;
    roi_window_crop_config dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .lowHPos, .lowHWidth, .lowVPos, .lowVHeight, .vPosRow6, .hPosCol6, .hWidthCol6, .activeHPos,
        .activeHWidth, .activeVPos, .activeVHeight, .linesPerFrame, .frameClocks, .configValid, .regionEnable);
    host_apb_master host (.clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    always @(posedge clk) begin
        for (int w = 0; w < 5; w++) begin
            lowHPos[w*13+:13] <= 13'(m[0][w]);
            lowVPos[w*12+:12] <= 12'(m[1][w]);
            lowHWidth[w*13+:13] <= 13'(m[2][w]);
            lowVHeight[w*12+:12] <= 12'(m[3][w]);
        end
        hPosCol6 <= 13'(m[0][5]);
        vPosRow6 <= 12'(m[1][5]);
        hWidthCol6 <= 13'(m[2][5]);
    end
    function automatic logic [31:0] step(input logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction
    function automatic int expStatus(input bit narrow);
        int sh = 0, sv = 0;
        bit ho = 1, vo = 1, m4 = 1;
        for (int w = 0; w < 8; w++) begin
            sh += m[2][w];
            sv += m[3][w];
            ho &= m[0][w] + m[2][w] < (w < 7 ? m[0][w+1] : 2464);
            vo &= m[1][w] + m[3][w] < (w < 7 ? m[1][w+1] : 2056);
            for (int k = 0; k < 4; k++) m4 &= m[k][w] % 4 == 0;
        end
        return {m4, sv >= 4, sh >= (narrow ? 516 : 258), vo, ho};
    endfunction
    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdCheck(input logic [9:0] idx, input logic [31:0] exp);
        host.xfer(1'b0, idx, 32'h0, q, err);
        checkWord(q, exp);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) rdCheck(10'(8'h3e + 2 * i), 0);
        rdCheck(`IDX_LINE_CLOCKS, `LINE_CLOCKS_RESET);
        host.xfer(1'b0, 10'h070, 32'h0, q, err);
        checkWord(q, 0);
        checkWord(err, 1);
        // Case 1 narrow depth, 2 no height, 3 right edge, 4 overlap, 5 unaligned width
        for (int c = 0; c < 6; c++) begin
            for (int w = 0; w < 8; w++) begin
                lfsr = step(lfsr);
                m[0][w] = w * 300 + (lfsr & 32'h3c);
                m[1][w] = w * 252;
                m[2][w] = 64;
                m[3][w] = c == 2 ? 0 : lfsr[14:8] & 7'h7c;
            end
            if (c == 3) m[2][7] = 400;
            if (c == 4) m[1][4] = m[1][3];
            if (c == 5) m[2][3] = 66;
            for (int i = 0; i < 9; i++) begin
                lfsr = step(lfsr);
                host.xfer(1'b1, 10'(8'h3e + 2 * i), {lfsr[31:13], 13'(m[(i+3)%4][5+(i+3)/4])}, q, err);
                rdCheck(10'(8'h3e + 2 * i), m[(i+3)%4][5+(i+3)/4]);
            end
            lineClk = lfsr[9:0] | 10'h100;
            host.xfer(1'b1, `IDX_LINE_CLOCKS, lineClk, q, err);
            host.xfer(1'b1, `IDX_CONTROL, {28'd0, lfsr[20], 1'b1, c == 1, 1'b1}, q, err);
            // Apply, frame clocks and enable settle within four cycles
            repeat (4) @(posedge clk);
            st = expStatus(c == 1);
            rdCheck(`IDX_STATUS, st);
            checkWord(configValid, &st[4:0]);
            checkWord(regionEnable, &st[4:0]);
            checkWord(activeHPos[6*13+:13], m[0][6]);
            checkWord(activeVPos[7*12+:12], m[1][7]);
            checkWord(activeHWidth[7*13+:13], m[2][7]);
            st = 38;
            for (int w = 0; w < 8; w++) st += m[3][w];
            checkWord(linesPerFrame, st);
            checkWord(frameClocks, st * lineClk);
            rdCheck(`IDX_FRAME_CLOCKS, st * lineClk);
        end
        print_verdict;
    end
    initial begin
        #(40 * 5000);
        fails++;
        print_verdict;
    end
endmodule
`default_nettype wire
